// [src/encoder_index_latch.sv]
// Encoder index qualification, position capture and register port
`timescale 1ns/1ps
`include "enc_index_defs.svh"

module encoder_index_latch
  import enc_index_pkg::*;
(
  // Clock and reset
  input  wire logic  mclk_in,
  input  wire logic  resetn_in,
  // Register port
  input  wire addr_t addr_in,
  input  wire word_t wdata_in,
  input  wire logic  wr_in,
  input  wire logic  rd_in,
  output word_t      rdata_out,
  // Encoder pins
  input  wire logic  enc_a_in,
  input  wire logic  enc_b_in,
  input  wire logic  enc_n_in,
  // Ramp generator position
  input  wire word_t ramp_position_in,
  // Interrupt
  output logic       irq_out
);
  logic [`CFG_WIDTH-1:0] cfg_reg;
  word_t                 step_factor_reg;
  word_t                 latch_reg;
  word_t                 ramp_latch_reg;
  word_t                 rdata_reg;
  logic                  status_reg;
  logic                  once_armed_reg;
  logic                  cond_d_reg;
  logic                  a_s;
  logic                  b_s;
  logic                  n_s;
  logic                  count;
  logic                  up;
  logic                  index_cond;
  logic                  index_event;
  logic                  armed_event;
  logic                  wr_cfg;
  logic                  wr_pos;
  logic                  wr_step;
  logic                  rd_status;
  word_t                 position;
  edge_mode_e            edge_mode;

  // Pin synchroniser and quadrature decoder
  enc_input_sync u_sync (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .enc_a_in  (enc_a_in),
    .enc_b_in  (enc_b_in),
    .enc_n_in  (enc_n_in),
    .a_out     (a_s),
    .b_out     (b_s),
    .n_out     (n_s),
    .count_out (count),
    .up_out    (up)
  );

  // Position accumulator
  enc_accumulator u_accu (
    .mclk_in        (mclk_in),
    .resetn_in      (resetn_in),
    .count_in       (count),
    .up_in          (up),
    .decimal_in     (cfg_reg[`CFG_DECIMAL]),
    .step_factor_in (step_factor_reg),
    .clear_in       (armed_event && cfg_reg[`CFG_CLR]),
    .load_in        (wr_pos),
    .load_value_in  (wdata_in),
    .position_out   (position)
  );

  // Register port decode
  assign wr_cfg    = wr_in && (addr_in == `OFS_ENCODER_CONFIG);
  assign wr_pos    = wr_in && (addr_in == `OFS_ENC_POSITION);
  assign wr_step   = wr_in && (addr_in == `OFS_STEP_FACTOR);
  assign rd_status = rd_in && (addr_in == `OFS_INDEX_STATUS);

  // Index condition from polarities
  always_comb begin
    index_cond = (n_s == cfg_reg[`CFG_POL_N]);
    if (!cfg_reg[`CFG_SKIP_AB]) begin
      index_cond = index_cond
                 && (a_s == cfg_reg[`CFG_POL_A])
                 && (b_s == cfg_reg[`CFG_POL_B]);
    end
  end

  // Previous index condition for edge sensing
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      cond_d_reg <= 1'b0;
    end else begin
      cond_d_reg <= index_cond;
    end
  end

  // Event sensitivity
  assign edge_mode = edge_mode_e'({cfg_reg[`CFG_NEG_EDGE],
                                   cfg_reg[`CFG_POS_EDGE]});
  always_comb begin
    unique case (edge_mode)
      EDGE_LEVEL:    index_event = index_cond;
      EDGE_ACTIVE:   index_event = index_cond && !cond_d_reg;
      EDGE_INACTIVE: index_event = !index_cond && cond_d_reg;
      EDGE_BOTH:     index_event = index_cond ^ cond_d_reg;
    endcase
  end

  // Event acts only when continuous or once-armed
  assign armed_event = index_event
                    && (cfg_reg[`CFG_CONT] || once_armed_reg);

  // Configuration and step factor registers
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      cfg_reg         <= `CFG_RESET;
      step_factor_reg <= `STEP_FACTOR_RESET;
    end else begin
      if (wr_cfg) begin
        cfg_reg <= wdata_in[`CFG_WIDTH-1:0];
      end
      if (wr_step) begin
        step_factor_reg <= wdata_in;
      end
    end
  end

  // One-shot arming; a config write with ONCE set re-arms over a same-cycle capture
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      once_armed_reg <= 1'b0;
    end else if (wr_cfg) begin
      once_armed_reg <= wdata_in[`CFG_ONCE];
    end else if (index_event && once_armed_reg) begin
      once_armed_reg <= 1'b0;
    end
  end

  // Capture of encoder and ramp positions
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      latch_reg      <= 32'h0000_0000;
      ramp_latch_reg <= 32'h0000_0000;
    end else if (armed_event) begin
      latch_reg <= position;
      if (cfg_reg[`CFG_LATCH_RAMP]) begin
        ramp_latch_reg <= ramp_position_in;
      end
    end
  end

  // Index-seen flag: a new event wins over the read clear
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      status_reg <= 1'b0;
    end else if (index_event) begin
      status_reg <= 1'b1;
    end else if (rd_status) begin
      status_reg <= 1'b0;
    end
  end

  // Read data, valid the cycle after the strobe
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_in) begin
      unique case (addr_in)
        `OFS_ENCODER_CONFIG: rdata_reg <= {21'h0, cfg_reg};
        `OFS_ENC_POSITION:   rdata_reg <= position;
        `OFS_INDEX_STATUS:   rdata_reg <= {31'h0, status_reg};
        `OFS_ENC_LATCH:      rdata_reg <= latch_reg;
        `OFS_RAMP_LATCH:     rdata_reg <= ramp_latch_reg;
        default:             rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign rdata_out = rdata_reg;
  assign irq_out   = status_reg;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  // Steps of a one-shot capture
  sequence seq_once_taken;
    index_event && once_armed_reg && !wr_cfg;
  endsequence
  sequence seq_disarmed;
    !once_armed_reg;
  endsequence

  AST_CAPTURE: assert property (
    armed_event |=> latch_reg == $past(position))
    else $error("capture missed encoder position");
  AST_CLEAR: assert property (
    armed_event && cfg_reg[`CFG_CLR] |=> position == 32'h0000_0000)
    else $error("position not cleared on index");
  AST_NO_CLEAR: assert property (
    armed_event && !cfg_reg[`CFG_CLR] && !wr_pos && !count
    |=> position == $past(position))
    else $error("position changed without clear");
  AST_RAMP: assert property (
    armed_event && cfg_reg[`CFG_LATCH_RAMP]
    |=> ramp_latch_reg == $past(ramp_position_in))
    else $error("ramp position not captured");
  AST_NO_RAMP: assert property (
    !cfg_reg[`CFG_LATCH_RAMP] |=> $stable(ramp_latch_reg))
    else $error("ramp latch moved while disabled");
  AST_LEVEL: assert property (
    edge_mode == EDGE_LEVEL |-> index_event == index_cond)
    else $error("level mode event mismatch");
  AST_RISE: assert property (
    edge_mode == EDGE_ACTIVE && index_event
    |-> index_cond && !$past(index_cond))
    else $error("event without activating edge");
  AST_FALL: assert property (
    edge_mode == EDGE_INACTIVE && index_event
    |-> !index_cond && $past(index_cond))
    else $error("event without deactivating edge");
  AST_BOTH: assert property (
    edge_mode == EDGE_BOTH && $changed(index_cond) && !$past(wr_cfg)
    |-> index_event)
    else $error("missed transition in both-edge mode");
  AST_ONCE: assert property (
    seq_once_taken ##1 seq_disarmed
    |-> !armed_event || cfg_reg[`CFG_CONT])
    else $error("one-shot acted twice");
  AST_CONT: assert property (
    index_event && cfg_reg[`CFG_CONT] |-> armed_event)
    else $error("continuous mode skipped an event");
  AST_IDLE: assert property (
    !cfg_reg[`CFG_CONT] && !once_armed_reg
    |=> latch_reg == $past(latch_reg))
    else $error("capture while disarmed");
  AST_MATCH: assert property (
    !cfg_reg[`CFG_SKIP_AB]
    && (a_s != cfg_reg[`CFG_POL_A] || b_s != cfg_reg[`CFG_POL_B])
    |-> !index_cond)
    else $error("index qualified against phase mismatch");
  AST_SKIP: assert property (
    cfg_reg[`CFG_SKIP_AB] |-> index_cond == (n_s == cfg_reg[`CFG_POL_N]))
    else $error("phases not ignored");
  AST_POL_N: assert property (
    n_s != cfg_reg[`CFG_POL_N] |-> !index_cond)
    else $error("index active at wrong level");
  AST_STATUS: assert property (
    index_event |=> status_reg ##1 (irq_out || $past(rd_status)))
    else $error("index-seen flag not set");
  AST_STATUS_CLR: assert property (
    rd_status && !index_event |=> !status_reg)
    else $error("flag not cleared by read");
  AST_SYNC: assert property (
    $rose(enc_n_in) ##1 enc_n_in [*2] |-> n_s)
    else $error("index pin not synchronised in two cycles");
  AST_FLAG_WINS: assert property (
    index_event && rd_status |=> status_reg)
    else $error("read clear beat a new index event");
  AST_RISE_HIT: assert property (
    edge_mode == EDGE_ACTIVE && index_cond && !$past(index_cond)
    |-> index_event)
    else $error("activating edge missed");
  AST_FALL_HIT: assert property (
    edge_mode == EDGE_INACTIVE && !index_cond && $past(index_cond)
    |-> index_event)
    else $error("deactivating edge missed");
  AST_ONCE_ARM: assert property (
    wr_cfg && wdata_in[`CFG_ONCE] |=> once_armed_reg)
    else $error("one-shot not armed by config write");
  AST_LATCH_HOLD: assert property (
    !armed_event |=> $stable(latch_reg))
    else $error("capture register moved without event");
  AST_IDLE_POS: assert property (
    index_event && !cfg_reg[`CFG_CONT] && !once_armed_reg && !wr_pos
    && !count |=> position == $past(position))
    else $error("position changed while disarmed");
endmodule

// [src/enc_index_defs.svh]
// Register offsets, field positions and reset values of the index latch
`ifndef ENC_INDEX_DEFS_SVH
`define ENC_INDEX_DEFS_SVH

// Register offsets on the plain register port
`define OFS_ENCODER_CONFIG 7'h38
`define OFS_ENC_POSITION   7'h39
`define OFS_STEP_FACTOR    7'h3A
`define OFS_INDEX_STATUS   7'h3B
`define OFS_ENC_LATCH      7'h3C
`define OFS_RAMP_LATCH     7'h3D

// Field positions of encoder_config
`define CFG_POL_A      0
`define CFG_POL_B      1
`define CFG_POL_N      2
`define CFG_SKIP_AB    3
`define CFG_CONT       4
`define CFG_ONCE       5
`define CFG_POS_EDGE   6
`define CFG_NEG_EDGE   7
`define CFG_CLR        8
`define CFG_LATCH_RAMP 9
`define CFG_DECIMAL    10
`define CFG_WIDTH      11

// Reset values and fraction moduli
`define CFG_RESET         11'h000
`define STEP_FACTOR_RESET 32'h0000_0000
`define FRAC_MOD_BINARY   17'h1_0000
`define FRAC_MOD_DECIMAL  17'h0_2710

`endif

// [src/enc_index_pkg.sv]
// Types shared by the encoder index latch modules
package enc_index_pkg;
  typedef logic [31:0] word_t;
  typedef logic [6:0]  addr_t;
  // Index sensitivity, decoded from {falling, rising} bits
  typedef enum logic [1:0] {
    EDGE_LEVEL,
    EDGE_ACTIVE,
    EDGE_INACTIVE,
    EDGE_BOTH
  } edge_mode_e;
endpackage

// [src/enc_input_sync.sv]
// Encoder pin synchroniser and quadrature step decoder
`timescale 1ns/1ps
module enc_input_sync (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic resetn_in,
  // Raw encoder pins
  input  wire logic enc_a_in,
  input  wire logic enc_b_in,
  input  wire logic enc_n_in,
  // Synchronised levels and step events
  output logic      a_out,
  output logic      b_out,
  output logic      n_out,
  output logic      count_out,
  output logic      up_out
);
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [1:0] prev_ab_reg;

  // Two flops per pin before any logic looks at it
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
    end else begin
      meta_reg <= {enc_n_in, enc_b_in, enc_a_in};
      sync_reg <= meta_reg;
    end
  end

  // Previous A/B pair for step detection
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      prev_ab_reg <= 2'h0;
    end else begin
      prev_ab_reg <= sync_reg[1:0];
    end
  end

  assign a_out = sync_reg[0];
  assign b_out = sync_reg[1];
  assign n_out = sync_reg[2];

  // One step when exactly one phase changed; A leading B counts up
  assign count_out = (sync_reg[0] ^ prev_ab_reg[0])
                   ^ (sync_reg[1] ^ prev_ab_reg[1]);
  assign up_out    = sync_reg[0] ^ prev_ab_reg[1];
endmodule

// [src/enc_accumulator.sv]
// Encoder position accumulator with binary or decimal fraction
`timescale 1ns/1ps
`include "enc_index_defs.svh"
module enc_accumulator
  import enc_index_pkg::*;
(
  // Clock and reset
  input  wire logic  mclk_in,
  input  wire logic  resetn_in,
  // Step events and settings
  input  wire logic  count_in,
  input  wire logic  up_in,
  input  wire logic  decimal_in,
  input  wire word_t step_factor_in,
  // Clear on index and software load
  input  wire logic  clear_in,
  input  wire logic  load_in,
  input  wire word_t load_value_in,
  // Integer part of the position
  output word_t      position_out
);
  word_t       pos_reg;
  logic [15:0] frac_reg;
  logic [16:0] mod;
  logic [16:0] sum;
  logic        carry;
  logic [15:0] frac_next;
  word_t       int_step;
  word_t       pos_next;

  // Fraction wraps at the selected modulus, carry goes to the integer
  always_comb begin
    mod      = decimal_in ? `FRAC_MOD_DECIMAL : `FRAC_MOD_BINARY;
    int_step = {{16{step_factor_in[31]}}, step_factor_in[31:16]};
    sum      = {1'b0, frac_reg} + {1'b0, step_factor_in[15:0]};
    if (up_in) begin
      carry     = (sum >= mod);
      frac_next = carry ? 16'(sum - mod) : sum[15:0];
      pos_next  = pos_reg + int_step + {31'h0, carry};
    end else begin
      carry     = (frac_reg < step_factor_in[15:0]);
      frac_next = carry ? 16'({1'b0, frac_reg} + mod
                              - {1'b0, step_factor_in[15:0]})
                        : 16'(frac_reg - step_factor_in[15:0]);
      pos_next  = pos_reg - int_step - {31'h0, carry};
    end
  end

  // Clear beats load, load beats counting
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      pos_reg  <= 32'h0000_0000;
      frac_reg <= 16'h0000;
    end else if (clear_in) begin
      pos_reg  <= 32'h0000_0000;
      frac_reg <= 16'h0000;
    end else if (load_in) begin
      pos_reg  <= load_value_in;
      frac_reg <= 16'h0000;
    end else if (count_in) begin
      pos_reg  <= pos_next;
      frac_reg <= frac_next;
    end
  end

  assign position_out = pos_reg;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  AST_BINARY_UP: assert property (
    count_in && up_in && !decimal_in && !clear_in && !load_in
    |=> {pos_reg, frac_reg} == $past({pos_reg, frac_reg})
        + {{16{$past(step_factor_in[31])}}, $past(step_factor_in)})
    else $error("binary accumulation wrong");
  AST_DECIMAL_FRAC: assert property (
    count_in && decimal_in && frac_reg < 16'h2710
    && step_factor_in[15:0] < 16'h2710 && !clear_in && !load_in
    |=> frac_reg < 16'h2710)
    else $error("decimal fraction out of range");
endmodule

// [testbench/enc_model.sv]
// Behavioural quadrature encoder with index output
`timescale 1ns/1ps
module enc_model (
  // Clock
  input  wire logic mclk_in,
  // Encoder outputs
  output logic      enc_a_out,
  output logic      enc_b_out,
  output logic      enc_n_out
);
  logic [1:0] phase_reg = 2'h0;

  // Gray order 00, 10, 11, 01 as (A,B): A leads B counting up
  assign enc_a_out = phase_reg[0] ^ phase_reg[1];
  assign enc_b_out = phase_reg[1];

  // Index idles low
  initial begin
    enc_n_out = 1'b0;
  end

  // One step, then a pause so each change is seen on its own
  task automatic step(input logic up);
    @(posedge mclk_in);
    phase_reg <= up ? phase_reg + 2'h1 : phase_reg - 2'h1;
    repeat (5) @(posedge mclk_in);
  endtask

  // Index level change, then time to settle through the sync flops
  task automatic set_index(input logic level);
    @(posedge mclk_in);
    enc_n_out <= level;
    repeat (6) @(posedge mclk_in);
  endtask
endmodule

// [testbench/encoder_index_latch_tb.sv]
// Self-checking bench of the encoder index latch
`timescale 1ns/1ps
`include "enc_index_defs.svh"
module encoder_index_latch_tb;
  import enc_index_pkg::*;
  logic  mclk_in = 1'b0;
  logic  resetn_in = 1'b0;
  addr_t addr_in = 7'h00;
  word_t wdata_in = 32'h0000_0000;
  logic  wr_in = 1'b0;
  logic  rd_in = 1'b0;
  word_t ramp_position_in = 32'h1234_5678;
  word_t rdata_out;
  logic  enc_a, enc_b, enc_n, irq_out;
  int    fail_count = 0;
  int    cmp_count = 0;

  // 250 MHz clock
  always #2 mclk_in = ~mclk_in;

  encoder_index_latch encoder_index_latch_inst (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .enc_a_in(enc_a), .enc_b_in(enc_b),
    .enc_n_in(enc_n), .ramp_position_in(ramp_position_in),
    .irq_out(irq_out));

  enc_model enc_model_inst (
    .mclk_in(mclk_in), .enc_a_out(enc_a), .enc_b_out(enc_b),
    .enc_n_out(enc_n));

  // Verdict and end of run
  task automatic report_and_stop();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input word_t got, input word_t exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input addr_t a, input word_t d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd_chk(input addr_t a, input word_t exp);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask

  // Reset values, write-only and unmapped places
  task automatic t_reset();
    rd_chk(`OFS_ENCODER_CONFIG, 32'h0000_0000);
    rd_chk(`OFS_ENC_POSITION, 32'h0000_0000);
    rd_chk(`OFS_STEP_FACTOR, 32'h0000_0000);
    rd_chk(`OFS_ENC_LATCH, 32'h0000_0000);
    // Pins idle low and config zero: active-low index with A, B matching
    rd_chk(`OFS_INDEX_STATUS, 32'h0000_0001);
    wr(7'h10, 32'hFFFF_FFFF);
    rd_chk(7'h10, 32'h0000_0000);
    wr(`OFS_ENC_LATCH, 32'hFFFF_FFFF);
    rd_chk(`OFS_ENC_LATCH, 32'h0000_0000);
    chk({31'h0, irq_out}, 32'h0000_0001);
  endtask

  // Accumulation with signed 16.16 factor, binary and decimal fraction
  task automatic t_accum();
    wr(`OFS_STEP_FACTOR, 32'h0001_8000);
    wr(`OFS_ENC_POSITION, 32'h0000_0000);
    repeat (4) enc_model_inst.step(1'b1);
    rd_chk(`OFS_ENC_POSITION, 32'h0000_0006);
    repeat (2) enc_model_inst.step(1'b0);
    rd_chk(`OFS_ENC_POSITION, 32'h0000_0003);
    wr(`OFS_STEP_FACTOR, 32'h0000_1388);
    wr(`OFS_ENCODER_CONFIG, 32'h0000_0400);
    wr(`OFS_ENC_POSITION, 32'h0000_0000);
    repeat (2) enc_model_inst.step(1'b1);
    rd_chk(`OFS_ENC_POSITION, 32'h0000_0001);
    wr(`OFS_ENCODER_CONFIG, 32'h0000_0000);
    wr(`OFS_ENC_POSITION, 32'h0000_0000);
    repeat (2) enc_model_inst.step(1'b1);
    rd_chk(`OFS_ENC_POSITION, 32'h0000_0000);
  endtask

  // Continuous capture on rising index with ramp latch, no clear
  task automatic t_cont();
    wr(`OFS_ENC_POSITION, 32'h0000_0064);
    wr(`OFS_ENCODER_CONFIG, 32'h0000_025C);
    rd_chk(`OFS_INDEX_STATUS, 32'h0000_0001);
    enc_model_inst.set_index(1'b1);
    chk({31'h0, irq_out}, 32'h0000_0001);
    rd_chk(`OFS_ENC_LATCH, 32'h0000_0064);
    rd_chk(`OFS_RAMP_LATCH, 32'h1234_5678);
    ramp_position_in <= 32'h5A5A_00C3;
    rd_chk(`OFS_ENC_POSITION, 32'h0000_0064);
    rd_chk(`OFS_INDEX_STATUS, 32'h0000_0001);
    rd_chk(`OFS_INDEX_STATUS, 32'h0000_0000);
    enc_model_inst.set_index(1'b0);
    chk({31'h0, irq_out}, 32'h0000_0000);
    wr(`OFS_ENC_POSITION, 32'h0000_0070);
    enc_model_inst.set_index(1'b1);
    rd_chk(`OFS_ENC_LATCH, 32'h0000_0070);
    rd_chk(`OFS_RAMP_LATCH, 32'h5A5A_00C3);
    rd_chk(`OFS_INDEX_STATUS, 32'h0000_0001);
    enc_model_inst.set_index(1'b0);
  endtask

  // All four sensitivities, unarmed so nothing is captured
  task automatic t_modes();
    logic [1:0] m;
    wr(`OFS_ENC_POSITION, 32'h0000_0055);
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      wr(`OFS_ENCODER_CONFIG, {24'h0, m, 6'h0C});
      rd_chk(`OFS_INDEX_STATUS, 32'h0000_0000);
      enc_model_inst.set_index(1'b1);
      rd_chk(`OFS_INDEX_STATUS, {31'h0, m != 2'h2});
      rd_chk(`OFS_INDEX_STATUS, {31'h0, m == 2'h0});
      enc_model_inst.set_index(1'b0);
      rd_chk(`OFS_INDEX_STATUS, {31'h0, m != 2'h1});
    end
    rd_chk(`OFS_ENC_LATCH, 32'h0000_0070);
    rd_chk(`OFS_ENC_POSITION, 32'h0000_0055);
  endtask

  // Single capture with clear, then disarmed
  task automatic t_once();
    ramp_position_in <= 32'h0F0F_1111;
    wr(`OFS_ENC_POSITION, 32'h0000_0020);
    wr(`OFS_ENCODER_CONFIG, 32'h0000_016C);
    enc_model_inst.set_index(1'b1);
    rd_chk(`OFS_ENC_LATCH, 32'h0000_0020);
    rd_chk(`OFS_ENC_POSITION, 32'h0000_0000);
    enc_model_inst.set_index(1'b0);
    wr(`OFS_ENC_POSITION, 32'h0000_0030);
    enc_model_inst.set_index(1'b1);
    rd_chk(`OFS_ENC_LATCH, 32'h0000_0020);
    rd_chk(`OFS_ENC_POSITION, 32'h0000_0030);
    rd_chk(`OFS_INDEX_STATUS, 32'h0000_0001);
    rd_chk(`OFS_RAMP_LATCH, 32'h5A5A_00C3);
    enc_model_inst.set_index(1'b0);
  endtask

  // Index qualified by A and B levels, only matching pair gives event
  task automatic t_match();
    for (int k = 0; k < 4 && enc_model_inst.phase_reg != 2'h2; k++) begin
      enc_model_inst.step(1'b1);
    end
    for (int p = 0; p < 4; p++) begin
      wr(`OFS_ENCODER_CONFIG, {24'h0, 8'h54 | p[7:0]});
      rd_chk(`OFS_INDEX_STATUS, 32'h0000_0000);
      enc_model_inst.set_index(1'b1);
      rd_chk(`OFS_INDEX_STATUS, {31'h0, p == 3});
      enc_model_inst.set_index(1'b0);
    end
    // Active-low index: low pin qualifies, the config change is an edge
    wr(`OFS_ENCODER_CONFIG, 32'h0000_0048);
    rd_chk(`OFS_INDEX_STATUS, 32'h0000_0001);
    enc_model_inst.set_index(1'b1);
    rd_chk(`OFS_INDEX_STATUS, 32'h0000_0000);
    enc_model_inst.set_index(1'b0);
    rd_chk(`OFS_INDEX_STATUS, 32'h0000_0001);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge mclk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_accum();
    t_cont();
    t_modes();
    t_once();
    t_match();
    report_and_stop();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk_in);
    fail_count++;
    report_and_stop();
  end
endmodule
